// >>> tft_params.svh
// timing constants and pin layout for the tft panel data-enable link
`ifndef TFT_PARAMS_SVH
`define TFT_PARAMS_SVH

`define TFT_COLOR_W 6
`define TFT_PIX_W 18
`define TFT_TOUCH_W 12
`define TFT_FIFO_DEPTH 16

`define TFT_SYS_PERIOD_PS 10000
`define TFT_PIX_PERIOD_PS 25130
// round up to whole cycles, then up to even so the duty is exactly half
`define TFT_PCLK_DIV ((((`TFT_PIX_PERIOD_PS + `TFT_SYS_PERIOD_PS - 1) / `TFT_SYS_PERIOD_PS) + 1) / 2 * 2)

`define TFT_H_TOTAL 11'd1056
`define TFT_H_MIN 12'd1000
`define TFT_H_ACTIVE 11'd800
`define TFT_V_ACTIVE 10'd600
`define TFT_BLANK_MIN 7'd10
`define TFT_BLANK_TYP 7'd28
`define TFT_BLANK_MAX 7'd110
`define TFT_GAP_CLKS 12'd2000

`define TFT_GSP_DLY 12'd4
`define TFT_GCK_DLY 12'd40
`define TFT_GCK_W 12'd133
`define TFT_GOE_DLY 12'd23
`define TFT_GOE_W 12'd150
`define TFT_PTG_DLY 12'd157

`endif

// >>> tft_pkg.sv
// shared types of the tft panel link
`default_nettype none
package tft_pkg;
  typedef logic [5:0] tft_color_type;
  typedef logic [17:0] tft_pixel_type;
  typedef enum logic [0:0] {
    TFT_V_ACT = 1'b0,
    TFT_V_BLANK = 1'b1
  } tft_vstate_type;
endpackage
`default_nettype wire

// >>> tft_if.sv
// link between the display controller and the panel
`timescale 1ns/100ps
`default_nettype none
interface tft_if;
  logic panel_pixel_clock;
  logic rgb_data_enable;
  tft_pkg::tft_color_type red_bus;
  tft_pkg::tft_color_type green_bus;
  tft_pkg::tft_color_type blue_bus;
  logic backlight_enable;
  modport host (
    output panel_pixel_clock,
    output rgb_data_enable,
    output red_bus,
    output green_bus,
    output blue_bus,
    output backlight_enable
  );
  modport panel (
    input panel_pixel_clock,
    input rgb_data_enable,
    input red_bus,
    input green_bus,
    input blue_bus,
    input backlight_enable
  );
endinterface
`default_nettype wire

// >>> tft_host.sv
// display controller end: pixel fifo and data-enable timing generator
`timescale 1ns/100ps
`default_nettype none
`include "tft_params.svh"

module tft_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module tft_host (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [17:0] pix_data_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [6:0] blank_lines_i,
  input wire logic backlight_on_i,
  output logic frame_start_o,
  output logic underflow_o,
  tft_if.host link
);
  localparam logic [1:0] PH_LAST = 2'(`TFT_PCLK_DIV - 1);

  logic [1:0] phase_q;
  logic pclk_q;
  logic [10:0] h_q;
  logic [9:0] v_q;
  logic [6:0] blank_q;
  logic de_q;
  tft_pkg::tft_pixel_type rgb_q;
  logic bl_q;
  logic fs_q;
  logic uf_q;
  tft_pkg::tft_vstate_type vst_d;

  ////////////////////////////////////////////////////////////////////////////////
  // pixel fifo; the generator drains one word per active pixel

  tft_pkg::tft_pixel_type fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  tft_fifo #(
    .WIDTH(`TFT_PIX_W),
    .DEPTH(`TFT_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(pix_data_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pixel clock divider: low for half, high for half

  wire tick = (phase_q == PH_LAST);
  wire [1:0] phase_d = tick ? 2'h0 : phase_q + 2'h1;
  wire pclk_d = phase_d[1];

  ////////////////////////////////////////////////////////////////////////////////
  // raster position of the pixel about to be shown

  wire [6:0] blank_clamp = (blank_lines_i < `TFT_BLANK_MIN) ? `TFT_BLANK_MIN :
                           (blank_lines_i > `TFT_BLANK_MAX) ? `TFT_BLANK_MAX : blank_lines_i;
  wire line_end = (h_q == `TFT_H_TOTAL - 11'd1);
  wire [9:0] v_last = `TFT_V_ACTIVE + {3'h0, blank_q} - 10'd1;
  wire frame_end = line_end && (v_q == v_last);
  wire [10:0] h_d = line_end ? 11'h000 : h_q + 11'd1;
  wire [9:0] v_d = frame_end ? 10'h000 : (line_end ? v_q + 10'd1 : v_q);
  wire h_act = (h_d < `TFT_H_ACTIVE);

  always_comb begin
    vst_d = (v_d < `TFT_V_ACTIVE) ? tft_pkg::TFT_V_ACT : tft_pkg::TFT_V_BLANK;
  end

  logic act_d;
  always_comb begin
    case (vst_d)
      tft_pkg::TFT_V_ACT: begin
        act_d = h_act;
      end
      tft_pkg::TFT_V_BLANK: begin
        act_d = 1'b0;
      end
      default: begin
        act_d = 1'b0;
      end
    endcase
  end

  assign fifo_pop = tick && act_d;
  // underflow shows black rather than stalling the raster, which cannot wait
  wire [17:0] rgb_d = (act_d && fifo_valid) ? fifo_data : 18'h0_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // data enable and colour change at the falling pixel clock, panel samples them on the rise

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= 2'h0;
      pclk_q <= 1'b0;
      bl_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      pclk_q <= pclk_d;
      bl_q <= backlight_on_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_q <= `TFT_H_TOTAL - 11'd1;
      v_q <= `TFT_V_ACTIVE + 10'd9;
      blank_q <= `TFT_BLANK_MIN;
    end else if (tick) begin
      h_q <= h_d;
      v_q <= v_d;
      if (frame_end) begin
        blank_q <= blank_clamp;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      de_q <= 1'b0;
      rgb_q <= 18'h0_0000;
    end else if (tick) begin
      de_q <= act_d;
      rgb_q <= rgb_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fs_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      fs_q <= tick && frame_end;
      uf_q <= tick && act_d && !fifo_valid;
    end
  end

  assign frame_start_o = fs_q;
  assign underflow_o = uf_q;
  assign link.panel_pixel_clock = pclk_q;
  assign link.rgb_data_enable = de_q;
  assign link.red_bus = rgb_q[17:12];
  assign link.green_bus = rgb_q[11:6];
  assign link.blue_bus = rgb_q[5:0];
  assign link.backlight_enable = bl_q;
endmodule
`default_nettype wire

// >>> tft_panel.sv
// panel end: samples the link and derives gate-driver strobes
`timescale 1ns/100ps
`default_nettype none
`include "tft_params.svh"

module tft_panel (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  tft_if.panel link,
  output logic gate_start_pulse_o,
  output logic gate_clock_pulse_o,
  output logic gate_output_enable_o,
  output logic polarity_toggle_o,
  output logic pix_valid_o,
  output logic [9:0] pix_x_o,
  output logic [9:0] pix_y_o,
  output logic [17:0] pix_rgb_o,
  output logic backlight_o,
  output logic line_short_o,
  output logic width_err_o
);
  localparam int SW = 21;

  function automatic logic in_win(input logic [11:0] c, input logic [11:0] s, input logic [11:0] w);
    in_win = (c >= s) && (c < s + w);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // three-stage capture; a bit changes only when stages two and three agree

  wire [SW-1:0] raw = {link.panel_pixel_clock, link.rgb_data_enable, link.backlight_enable,
                       link.red_bus, link.green_bus, link.blue_bus};
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] lvl_q;
  logic [SW-1:0] lvl_d;

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_sync
      assign lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  wire pix_rise = lvl_d[20] && !lvl_q[20];
  wire de_now = lvl_d[19];
  wire [17:0] rgb_now = lvl_d[17:0];

  ////////////////////////////////////////////////////////////////////////////////
  // pixel clocks since the internal data enable rose, and line index

  logic de_prev_q;
  logic [11:0] cnt_q;
  logic [9:0] row_q;
  wire de_rise = de_now && !de_prev_q;
  wire de_fall = !de_now && de_prev_q;
  wire [11:0] cnt_inc = (cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'd1;
  wire [11:0] cnt_d = de_rise ? 12'h000 : cnt_inc;
  // long quiet gap also restarts the frame, so a short frame cannot desync us
  wire frame_new = (row_q == `TFT_V_ACTIVE - 10'd1) || (cnt_q >= `TFT_GAP_CLKS);
  wire [9:0] row_d = de_rise ? (frame_new ? 10'h000 : row_q + 10'd1) : row_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      de_prev_q <= 1'b0;
      cnt_q <= 12'hFFF;
      row_q <= `TFT_V_ACTIVE - 10'd1;
    end else if (pix_rise) begin
      de_prev_q <= de_now;
      cnt_q <= cnt_d;
      row_q <= row_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gate-driver strobes timed from the internal data enable

  logic gsp_q;
  logic gck_q;
  logic goe_q;
  logic ptg_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gsp_q <= 1'b0;
      gck_q <= 1'b0;
      goe_q <= 1'b0;
      ptg_q <= 1'b0;
    end else if (pix_rise) begin
      if (cnt_d == `TFT_GSP_DLY) begin
        gsp_q <= (row_d == 10'h000);
      end
      gck_q <= in_win(cnt_d, `TFT_GCK_DLY, `TFT_GCK_W);
      goe_q <= in_win(cnt_d, `TFT_GOE_DLY, `TFT_GOE_W);
      if (cnt_d == `TFT_PTG_DLY) begin
        ptg_q <= !ptg_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // captured pixels and timing checks

  logic pv_q;
  logic [9:0] px_q;
  logic [9:0] py_q;
  logic [17:0] prgb_q;
  logic ls_q;
  logic we_q;
  wire in_frame = (row_d < `TFT_V_ACTIVE) && (cnt_d < {1'b0, `TFT_H_ACTIVE});
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pv_q <= 1'b0;
      px_q <= 10'h000;
      py_q <= 10'h000;
      prgb_q <= 18'h0_0000;
      ls_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      pv_q <= pix_rise && de_now && in_frame;
      ls_q <= pix_rise && de_rise && (cnt_inc < `TFT_H_MIN);
      we_q <= pix_rise && de_fall && (cnt_inc != {1'b0, `TFT_H_ACTIVE});
      if (pix_rise && de_now) begin
        px_q <= cnt_d[9:0];
        py_q <= row_d;
        prgb_q <= rgb_now;
      end
    end
  end

  assign gate_start_pulse_o = gsp_q;
  assign gate_clock_pulse_o = gck_q;
  assign gate_output_enable_o = goe_q;
  assign polarity_toggle_o = ptg_q;
  assign pix_valid_o = pv_q;
  assign pix_x_o = px_q;
  assign pix_y_o = py_q;
  assign pix_rgb_o = prgb_q;
  assign backlight_o = lvl_q[18];
  assign line_short_o = ls_q;
  assign width_err_o = we_q;
endmodule
`default_nettype wire

// >>> tft_link_assertions.sv
// concurrent checks on the pixel link between host and panel
`timescale 1ns/100ps
`default_nettype none
module tft_link_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic panel_pixel_clock,
  input wire logic rgb_data_enable,
  input wire tft_pkg::tft_color_type red_bus,
  input wire tft_pkg::tft_color_type green_bus,
  input wire tft_pkg::tft_color_type blue_bus
);
  // one line is 1056 pixel clocks of 4 sys cycles
  localparam int LINE = 32'h0000_1080;
  wire de = rgb_data_enable;
  wire pclk = panel_pixel_clock;
  wire [17:0] rgb = {red_bus, green_bus, blue_bus};
  logic [11:0] hi_q;
  logic [19:0] per_q;
  logic [9:0] lines_q;
  logic seen_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_q <= 12'h000;
      per_q <= 20'h0_0000;
      lines_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      hi_q <= de ? hi_q + 12'h001 : 12'h000;
      per_q <= $rose(de) ? 20'h0_0001 : per_q + 20'h0_0001;
      if ($rose(de)) begin
        lines_q <= (per_q == LINE) ? lines_q + 10'h001 : 10'h001;
      end
      seen_q <= seen_q | $rose(de);
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_high2;
    pclk [*2];
  endsequence
  sequence s_low2;
    !pclk [*2];
  endsequence
  chk_pclk_rise_shape: assert property ($rose(pclk) |-> s_high2 ##1 s_low2 ##1 pclk)
    else $error("pixel clock period not 4 cycles");
  chk_pclk_fall_shape: assert property ($fell(pclk) |-> s_low2 ##1 s_high2)
    else $error("pixel clock duty not half");
  chk_blank_black: assert property (!de |-> rgb == 18'h0_0000)
    else $error("colour not black while disabled");
  chk_link_change_low: assert property ($changed(de) || $changed(rgb) |-> !pclk)
    else $error("link changed while pixel clock high");
  chk_de_width: assert property ($fell(de) |-> hi_q == 12'hc80)
    else $error("enable width not 800 pixel clocks");
  chk_line_period: assert property ($rose(de) && seen_q |-> per_q != 0 && per_q % LINE == 0)
    else $error("line period not whole lines");
  chk_blank_range: assert property ($rose(de) && seen_q && per_q > LINE |->
    per_q >= 11 * LINE && per_q <= 111 * LINE)
    else $error("blank line count out of range");
  chk_frame_lines: assert property ($rose(de) && seen_q && per_q > LINE |-> lines_q == 10'h258)
    else $error("frame not 600 enabled lines");
endmodule
`default_nettype wire

// >>> tft_panel_de_timing_tb.sv
// self-checking bench: host and panel joined by the link
`timescale 1ns/100ps
`default_nettype none
module tft_panel_de_timing_tb;
  localparam int N_PUSH = 32'h0000_0640;
  localparam int H_ACT = 32'h0000_0320;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [17:0] pix_data_i = 18'h0_0000;
  logic pix_valid_i = 1'b0;
  logic backlight_on_i = 1'b0;
  logic pix_ready_o, underflow_o, gsp, gck, goe, ptg, pix_valid_o, backlight_o, line_short_o, width_err_o;
  logic frame_start_o;
  int n_fs = 0;
  logic [9:0] pix_x_o, pix_y_o;
  logic [17:0] pix_rgb_o;
  logic [3:0] g_now, g_prev;
  logic saw_full = 1'b0;
  logic saw_under = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int cap = 0;
  int t_rise[4];
  int t_fall[4];
  tft_if link ();
  tft_host u_tft_host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pix_data_i(pix_data_i),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .blank_lines_i(7'h1c),
    .backlight_on_i(backlight_on_i), .frame_start_o(frame_start_o), .underflow_o(underflow_o), .link(link));
  tft_panel u_tft_panel (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .link(link), .gate_start_pulse_o(gsp),
    .gate_clock_pulse_o(gck), .gate_output_enable_o(goe), .polarity_toggle_o(ptg),
    .pix_valid_o(pix_valid_o), .pix_x_o(pix_x_o), .pix_y_o(pix_y_o), .pix_rgb_o(pix_rgb_o),
    .backlight_o(backlight_o), .line_short_o(line_short_o), .width_err_o(width_err_o));
  tft_link_chk u_tft_link_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .panel_pixel_clock(link.panel_pixel_clock), .rgb_data_enable(link.rgb_data_enable),
    .red_bus(link.red_bus), .green_bus(link.green_bus), .blue_bus(link.blue_bus));
  always #5 sys_clk_i = ~sys_clk_i;
  assign g_now = {ptg, goe, gck, gsp};
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] pat(input int i);
    return 18'(i) ^ 18'h2_5a5a;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ready is sampled at the edge, before that edge's updates land
  task automatic push(input logic [17:0] d);
    pix_data_i <= d;
    pix_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pix_ready_o !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge sys_clk_i);
    end
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    g_prev <= g_now;
    if (underflow_o === 1'b1) saw_under <= 1'b1;
    if (frame_start_o === 1'b1) n_fs <= n_fs + 1;
    if (line_short_o !== 1'b0 || width_err_o !== 1'b0) check({line_short_o, width_err_o}, 0);
    if (pix_valid_o === 1'b1) begin
      check(pix_x_o, cap % H_ACT);
      check(pix_y_o, cap / H_ACT);
      // pixels past the pushed ones went out black after underflow
      check(pix_rgb_o, cap < N_PUSH ? pat(cap) : 18'h0_0000);
      cap <= cap + 1;
    end
    for (int i = 0; i < 4; i++) begin
      if (g_now[i] === 1'b1 && g_prev[i] === 1'b0 && t_rise[i] == 0) t_rise[i] <= cyc;
      if (g_now[i] === 1'b0 && g_prev[i] === 1'b1 && t_fall[i] == 0) t_fall[i] <= cyc;
    end
    if (cyc > 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    backlight_on_i = 1'b1;
    for (int i = 0; i < N_PUSH; i++) push(pat(i));
    pix_valid_i <= 1'b0;
    check(saw_full, 1);
    while (cap < 3 * H_ACT) @(posedge sys_clk_i);
    // strobe spacing in sys cycles, 4 per pixel clock
    check(t_fall[0] - t_rise[0], 32'h0000_1080);
    check(t_rise[2] - t_rise[0], 32'h0000_004c);
    check(t_rise[1] - t_rise[2], 32'h0000_0044);
    check(t_rise[3] - t_rise[2], 32'h0000_0218);
    check(t_fall[2] - t_rise[2], 32'h0000_0258);
    check(t_fall[1] - t_rise[1], 32'h0000_0214);
    check(saw_under, 1);
    // one wrap to line 0 right after reset; the next frame lies far beyond the run
    check(n_fs, 1);
    check(backlight_o, 1);
    #1;
    backlight_on_i = 1'b0;
    repeat (64) @(posedge sys_clk_i);
    check(backlight_o, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
